// *** dv/erc_regs_chk.sv ***
// Assertions for the RAM control and status register bank.
// Assumes binding to erc_regs; sees only its ports.
`timescale 1ns/100ps
module erc_regs_chk
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [31:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [erc_pkg::PERM_W-1:0] i_nv_perm_fabric,
    input wire logic [erc_pkg::NUM_BANKS-1:0] i_err_1bit,
    input wire logic [erc_pkg::NUM_BANKS-1:0] i_err_2bit,
    input wire logic [erc_pkg::WAIT_W-1:0] o_bank0_max_wait,
    input wire logic [erc_pkg::WAIT_W-1:0] o_bank1_max_wait,
    input wire logic o_read_pipeline_on,
    input wire logic [erc_pkg::NUM_BANKS-1:0] o_ecc_enable,
    input wire logic [erc_pkg::NUM_BANKS-1:0] o_ecc_soft_reset,
    input wire logic o_irq
);
    import erc_pkg::*;
    logic wr_ok;
    logic wr_any;
    logic rd_ok;
    logic any_err;
    function automatic logic [3:0] lat_dec(input logic [2:0] f);
        return (f == 3'h0) ? 4'h8 : {1'b0, f};
    endfunction : lat_dec
    assign wr_any = i_avs_write && !o_avs_waitrequest;
    assign wr_ok = wr_any && i_avs_byteenable[0];
    assign rd_ok = i_avs_read && !o_avs_waitrequest;
    assign any_err = |{i_err_1bit, i_err_2bit};
    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);
    // ------------------------------------------------------------
    // Register properties
    // ------------------------------------------------------------
    // one wait state
    AST_WAIT_ONE: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest longer than one cycle");
    AST_LAT_WRITE: assert property (
        wr_ok && i_avs_address == ADDR_MAX_LATENCY |=> o_bank0_max_wait == lat_dec($past(i_avs_writedata[2:0]))
        && o_bank1_max_wait == lat_dec($past(i_avs_writedata[5:3])))
        else $error("latency outputs not decoded from write");
    AST_LAT_RANGE: assert property (
        o_bank0_max_wait != 4'h0 && o_bank0_max_wait <= 4'h8 && o_bank1_max_wait != 4'h0 && o_bank1_max_wait <= 4'h8)
        else $error("wait cycles outside one to eight");
    AST_PIPE_WRITE: assert property (
        wr_ok && i_avs_address == ADDR_PIPELINE |=> o_read_pipeline_on == $past(i_avs_writedata[0]))
        else $error("pipeline output not written");
    AST_CTRL_WRITE: assert property (
        wr_ok && i_avs_address == ADDR_ECC_CONTROL |=> {o_ecc_soft_reset, o_ecc_enable} == $past(i_avs_writedata[3:0]))
        else $error("control outputs not written");
    AST_PERM_READ: assert property (
        rd_ok && i_avs_address == ADDR_PERM_FABRIC |-> o_avs_readdata == {{(32-PERM_W){1'b0}}, i_nv_perm_fabric})
        else $error("permission read differs from programmed bits");
    AST_CLR_READ: assert property (
        rd_ok && i_avs_address == ADDR_COUNTER_CLEAR |-> o_avs_readdata == 32'h0)
        else $error("counter clear register read nonzero");
    AST_IRQ_RISE: assert property (
        $rose(o_irq) |-> $past(any_err, 2) || $past(wr_any, 2))
        else $error("irq rose without event or write");
    AST_IRQ_FALL: assert property (
        $fell(o_irq) |-> $past(wr_any, 2))
        else $error("irq fell without a write");
endmodule : erc_regs_chk
bind erc_regs erc_regs_chk u_chk (.*);

// *** dv/erc_regs_tb.sv ***
// Self-checking bench for the RAM control and status register bank.
// Assumes erc_regs with the checker bound; bench acts as bus master.
`timescale 1ns/100ps
module erc_regs_tb;
    import erc_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [31:0] i_avs_address = 32'h0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [3:0] i_avs_byteenable = 4'hf;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [5:0] i_nv_latency_cfg = 6'h03;
    logic i_nv_pipeline_on = 1'b0;
    logic [CTRL_W-1:0] i_nv_ecc_control = 4'h3;
    logic [FLAG_W-1:0] i_nv_update_enable = 4'hf;
    logic [PERM_W-1:0] i_nv_perm_fabric = 10'h2a5;
    logic [PERM_W-1:0] i_nv_perm_dma = 10'h15a;
    logic [PERM_W-1:0] i_nv_perm_ninth = 10'h3c3;
    logic [NUM_BANKS-1:0] i_err_1bit = 2'h0;
    logic [NUM_BANKS-1:0] i_err_2bit = 2'h0;
    logic [ERR_ADDR_W-1:0] i_bank0_err_addr = 13'h0;
    logic [ERR_ADDR_W-1:0] i_bank1_err_addr = 13'h0;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [WAIT_W-1:0] o_bank0_max_wait;
    logic [WAIT_W-1:0] o_bank1_max_wait;
    logic o_read_pipeline_on;
    logic [NUM_BANKS-1:0] o_ecc_enable;
    logic [NUM_BANKS-1:0] o_ecc_soft_reset;
    logic o_irq;
    int bad_count = 0;
    int checks_done = 0;

    erc_regs uut (.*);

    always #25 i_sys_clk = ~i_sys_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        logic ok;
        n = 0;
        ok = 1'b0;
        @(posedge i_sys_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        while (!ok)
        begin
            @(posedge i_sys_clk);
            ok = (o_avs_waitrequest === 1'b0);
            q = o_avs_readdata;
            n++;
        end
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        chk("bus_edges", 32'h2, n);
        @(negedge i_sys_clk);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(name, exp, q);
    endtask : rdc

    task automatic pulse(input int b, input logic dbl, input logic [12:0] a, input int n);
        @(posedge i_sys_clk);
        if (b == 0)
            i_bank0_err_addr <= a;
        else
            i_bank1_err_addr <= a;
        if (dbl)
            i_err_2bit[b] <= 1'b1;
        else
            i_err_1bit[b] <= 1'b1;
        repeat (n) @(posedge i_sys_clk);
        i_err_1bit <= 2'h0;
        i_err_2bit <= 2'h0;
        @(negedge i_sys_clk);
    endtask : pulse

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rdc("latency", ADDR_MAX_LATENCY, 32'h3);
        chk("bank1_wait", 32'h8, {28'h0, o_bank1_max_wait});
        chk("pipeline", 32'h0, {31'h0, o_read_pipeline_on});
        rdc("perm_fabric", ADDR_PERM_FABRIC, 32'h2a5);
        rdc("perm_dma", ADDR_PERM_DMA, 32'h15a);
        rdc("perm_ninth", ADDR_PERM_NINTH, 32'h3c3);
        wr(ADDR_MAX_LATENCY, 32'hffff_ff3a);
        chk("bank0_wait", 32'h2, {28'h0, o_bank0_max_wait});
        rdc("latency", ADDR_MAX_LATENCY, 32'h3a);
        wr(ADDR_MAX_LATENCY, 32'h8);
        chk("bank0_wait", 32'h8, {28'h0, o_bank0_max_wait});
        wr(ADDR_PIPELINE, 32'h1);
        rdc("pipeline", ADDR_PIPELINE, 32'h1);
        wr(ADDR_PERM_FABRIC, 32'hffff_ffff);
        rdc("perm_fabric", ADDR_PERM_FABRIC, 32'h2a5);
        rdc("unmapped", 32'h4003_8000, 32'h0);
    endtask : t_regs

    task automatic t_err;
        wr(ADDR_IRQ_MASK, 32'hf);
        pulse(0, 1'b0, 13'h1abc, 3);
        pulse(1, 1'b1, 13'h0155, 1);
        rdc("ram0_counts", ADDR_RAM0_COUNTS, 32'h3);
        rdc("ram1_counts", ADDR_RAM1_COUNTS, 32'h0001_0000);
        rdc("ram0_addr", ADDR_RAM0_ERR_ADDR, 32'h1abc);
        rdc("ram1_addr", ADDR_RAM1_ERR_ADDR, 32'h002a_a000);
        rdc("status", ADDR_ERR_STATUS, 32'h9);
        wr(ADDR_ERR_STATUS, 32'h1);
        rdc("status", ADDR_ERR_STATUS, 32'h8);
        chk("irq", 32'h1, {31'h0, o_irq});
        wr(ADDR_ERR_STATUS, 32'h8);
        rdc("status", ADDR_ERR_STATUS, 32'h0);
        chk("irq", 32'h0, {31'h0, o_irq});
        wr(ADDR_IRQ_MASK, 32'h0);
        pulse(1, 1'b0, 13'h0007, 1);
        rdc("status", ADDR_ERR_STATUS, 32'h4);
        chk("irq", 32'h0, {31'h0, o_irq});
        wr(ADDR_IRQ_MASK, 32'h4);
        rdc("status", ADDR_ERR_STATUS, 32'h4);
        chk("irq", 32'h1, {31'h0, o_irq});
        wr(ADDR_ERR_STATUS, 32'h4);
    endtask : t_err

    task automatic t_gate;
        wr(ADDR_UPDATE_EN, 32'h0);
        pulse(0, 1'b0, 13'h0011, 1);
        rdc("status", ADDR_ERR_STATUS, 32'h0);
        wr(ADDR_ECC_CONTROL, 32'h2);
        pulse(0, 1'b0, 13'h0012, 2);
        rdc("ram0_counts", ADDR_RAM0_COUNTS, 32'h4);
        wr(ADDR_ECC_CONTROL, 32'h6);
        chk("soft_reset", 32'h1, {30'h0, o_ecc_soft_reset});
        rdc("ram0_counts", ADDR_RAM0_COUNTS, 32'h0);
        wr(ADDR_ECC_CONTROL, 32'h3);
        wr(ADDR_UPDATE_EN, 32'hf);
    endtask : t_gate

    // Saturation run dominates the cycle budget
    task automatic t_clear;
        pulse(0, 1'b0, 13'h0020, 2);
        wr(ADDR_COUNTER_CLEAR, 32'h2);
        rdc("ram1_counts", ADDR_RAM1_COUNTS, 32'h0);
        rdc("ram0_counts", ADDR_RAM0_COUNTS, 32'h2);
        wr(ADDR_COUNTER_CLEAR, 32'h1);
        rdc("ram0_counts", ADDR_RAM0_COUNTS, 32'h0);
        pulse(0, 1'b1, 13'h0021, 65537);
        rdc("ram0_counts", ADDR_RAM0_COUNTS, 32'hffff_0000);
    endtask : t_clear

    task automatic t_rerst;
        @(posedge i_sys_clk);
        i_sys_rst <= 1'b1;
        i_nv_latency_cfg <= 6'h38;
        i_nv_perm_fabric <= 10'h11b;
        repeat (2) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk("bank1_wait", 32'h7, {28'h0, o_bank1_max_wait});
        rdc("ram0_counts", ADDR_RAM0_COUNTS, 32'h0);
        rdc("status", ADDR_ERR_STATUS, 32'h0);
        rdc("perm_fabric", ADDR_PERM_FABRIC, 32'h11b);
    endtask : t_rerst

    task automatic stop_test;
        $display("checks_done %0d bad_count %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (2) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        t_regs();
        t_err();
        t_gate();
        t_clear();
        t_rerst();
        stop_test();
    end

    initial
    begin
        #4500000;
        bad_count++;
        $display("BAD watchdog expected done seen hang");
        stop_test();
    end
endmodule : erc_regs_tb

// *** verilog/erc_bank_err.sv ***
// Per-bank error tracker: saturating error counts and failing addresses.
// Assumes error strobes and address are synchronous to i_sys_clk.
`timescale 1ns/100ps
module erc_bank_err
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clear,
    input wire logic i_count_en,
    input wire logic i_err_1bit,
    input wire logic i_err_2bit,
    input wire logic [erc_pkg::ERR_ADDR_W-1:0] i_err_addr,
    output logic [erc_pkg::CNT_W-1:0] o_cnt_1e,
    output logic [erc_pkg::CNT_W-1:0] o_cnt_2e,
    output logic [erc_pkg::ERR_ADDR_W-1:0] o_addr_1e,
    output logic [erc_pkg::ERR_ADDR_W-1:0] o_addr_2e
);
    import erc_pkg::*;

    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------
    // Saturating counters
    // ------------------------------------------------------------
    // RL15 saturate not wrap
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_cnt_1e <= '0;
        // RL11 clear counts
        else if (i_clear)
            o_cnt_1e <= '0;
        else if (i_count_en && i_err_1bit && (o_cnt_1e != CNT_MAX))
            o_cnt_1e <= o_cnt_1e + CNT_ONE;
    end

    // RL15 saturate not wrap
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_cnt_2e <= '0;
        else if (i_clear)
            o_cnt_2e <= '0;
        else if (i_count_en && i_err_2bit && (o_cnt_2e != CNT_MAX))
            o_cnt_2e <= o_cnt_2e + CNT_ONE;
    end

    // ------------------------------------------------------------
    // Failing address capture
    // ------------------------------------------------------------
    // RL5 capture error address
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_addr_1e <= '0;
            o_addr_2e <= '0;
        end
        else
        begin
            if (i_count_en && i_err_1bit)
                o_addr_1e <= i_err_addr;
            if (i_count_en && i_err_2bit)
                o_addr_2e <= i_err_addr;
        end
    end

endmodule : erc_bank_err

// *** verilog/erc_pkg.sv ***
// Constants for the embedded RAM control and status register bank.
// Assumes a 32-bit Avalon-MM slave port decoding full byte addresses.
package erc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_MAX_LATENCY = 32'h4003_8004;
    localparam logic [31:0] ADDR_ECC_CONTROL = 32'h4003_8038;
    localparam logic [31:0] ADDR_UPDATE_EN = 32'h4003_8078;
    localparam logic [31:0] ADDR_PIPELINE = 32'h4003_8080;
    localparam logic [31:0] ADDR_RAM0_COUNTS = 32'h4003_80f0;
    localparam logic [31:0] ADDR_RAM1_COUNTS = 32'h4003_80f4;
    localparam logic [31:0] ADDR_RAM0_ERR_ADDR = 32'h4003_810c;
    localparam logic [31:0] ADDR_RAM1_ERR_ADDR = 32'h4003_8110;
    localparam logic [31:0] ADDR_PERM_FABRIC = 32'h4003_8128;
    localparam logic [31:0] ADDR_PERM_DMA = 32'h4003_812c;
    localparam logic [31:0] ADDR_PERM_NINTH = 32'h4003_8130;
    localparam logic [31:0] ADDR_ERR_STATUS = 32'h4003_8190;
    localparam logic [31:0] ADDR_COUNTER_CLEAR = 32'h4003_81a4;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h4003_81c0;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int NUM_BANKS = 2;
    localparam int LAT_W = 3;
    localparam int WAIT_W = 4;
    localparam int CNT_W = 16;
    localparam int ERR_ADDR_W = 13;
    localparam int PERM_W = 10;
    localparam int FLAG_W = 4;
    // Flag order per bank: single-bit at 2*b, double-bit at 2*b+1
    localparam int FLAG_1E = 0;
    localparam int FLAG_2E = 1;
    // Control: enables in [1:0], soft resets in [3:2]
    localparam int CTRL_W = 4;
    localparam int CTRL_SRST_LSB = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] RST_MAX_LATENCY = 6'h09;
    localparam logic RST_PIPELINE = 1'b1;
    localparam logic [CTRL_W-1:0] RST_ECC_CONTROL = 4'h0;
    localparam logic [FLAG_W-1:0] RST_UPDATE_EN = 4'h0;
    localparam logic [WAIT_W-1:0] LAT_ZERO_MEANS = 4'h8;

endpackage : erc_pkg

// *** verilog/erc_regs.sv ***
// Control and status register bank for two embedded RAM banks.
// Assumes an Avalon-MM master on i_sys_clk, static programmed bits,
// and error strobes from RAM logic on the same clock.
//
// Behaviour
// RL1 - Read-write register sets maximum wait cycles for each RAM bank.
// RL2 - Latency register loads the programmed configuration bits after reset.
// RL3 - Read-write register chooses whether a read pipeline stage is used.
// RL4 - Read-only register per bank reports its corrected error count.
// RL5 - Read-only register per bank captures the failing access address.
// RL6 - Three read-only registers give per-master-group read/write rights.
// RL7 - Permission registers come from programmed bits; writes never change them.
// RL8 - Status register holds single and double error flags per bank.
// RL9 - A flag sets on its error input and stays until cleared.
// RL10 - Writing one clears a status flag; writing zero leaves it.
// RL11 - Writing one to the clear register zeroes that bank's counters.
// RL12 - Enable register allows or suppresses status updates per bank.
// RL13 - Control register enables error logic and soft-resets it per bank.
// RL14 - Per-bank 3-bit latency field; zero means eight cycles.
// RL15 - Double count in upper half, single in lower; both saturate.
// RL16 - Pipeline bit one inserts the stage, zero bypasses it.
// RL17 - Error address register holds double and single addresses, 13 bits each.
// RL18 - Reset returns all registers to reset or programmed values.
// RL19 - Every register is one 32-bit word; unused bits read zero.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps
module erc_regs
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Avalon-MM slave
    input wire logic [31:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Programmed configuration bits
    input wire logic [5:0] i_nv_latency_cfg,
    input wire logic i_nv_pipeline_on,
    input wire logic [erc_pkg::CTRL_W-1:0] i_nv_ecc_control,
    input wire logic [erc_pkg::FLAG_W-1:0] i_nv_update_enable,
    input wire logic [erc_pkg::PERM_W-1:0] i_nv_perm_fabric,
    input wire logic [erc_pkg::PERM_W-1:0] i_nv_perm_dma,
    input wire logic [erc_pkg::PERM_W-1:0] i_nv_perm_ninth,
    // Error reports from the RAM banks
    input wire logic [erc_pkg::NUM_BANKS-1:0] i_err_1bit,
    input wire logic [erc_pkg::NUM_BANKS-1:0] i_err_2bit,
    input wire logic [erc_pkg::ERR_ADDR_W-1:0] i_bank0_err_addr,
    input wire logic [erc_pkg::ERR_ADDR_W-1:0] i_bank1_err_addr,
    // Controls to the RAM banks
    output logic [erc_pkg::WAIT_W-1:0] o_bank0_max_wait,
    output logic [erc_pkg::WAIT_W-1:0] o_bank1_max_wait,
    output logic o_read_pipeline_on,
    output logic [erc_pkg::NUM_BANKS-1:0] o_ecc_enable,
    output logic [erc_pkg::NUM_BANKS-1:0] o_ecc_soft_reset,
    output logic o_irq
);
    import erc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic ack_ff;
    logic load_pending_ff;
    logic [5:0] latency_ff;
    logic pipeline_ff;
    logic [CTRL_W-1:0] ecc_control_ff;
    logic [FLAG_W-1:0] update_en_ff;
    logic [FLAG_W-1:0] status_ff;
    logic [FLAG_W-1:0] mask_ff;
    logic [PERM_W-1:0] perm_fabric_ff;
    logic [PERM_W-1:0] perm_dma_ff;
    logic [PERM_W-1:0] perm_ninth_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] wmask;
    logic wr_fire;
    logic [FLAG_W-1:0] err_events;
    logic [NUM_BANKS-1:0] clr_pulse;
    logic [CNT_W-1:0] cnt_1e [NUM_BANKS];
    logic [CNT_W-1:0] cnt_2e [NUM_BANKS];
    logic [ERR_ADDR_W-1:0] adr_1e [NUM_BANKS];
    logic [ERR_ADDR_W-1:0] adr_2e [NUM_BANKS];
    logic [ERR_ADDR_W-1:0] bank_addr [NUM_BANKS];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // RL14 zero means eight
    function automatic logic [WAIT_W-1:0] lat_decode(input logic [LAT_W-1:0] fld);
        logic [WAIT_W-1:0] res;
        res = {1'b0, fld};
        if (fld == '0)
            res = LAT_ZERO_MEANS;
        return res;
    endfunction : lat_decode

    function automatic logic wr_hit(input logic [31:0] adr);
        return wr_fire && (i_avs_address == adr);
    endfunction : wr_hit

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait state: request seen on first edge, completed on second
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;
    assign wr_fire = i_avs_write && ack_ff;
    assign o_avs_readdata = rdata_ff;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ack_ff <= 1'b0;
        else
            ack_ff <= (i_avs_read || i_avs_write) && !ack_ff;
    end

    always_comb
    begin
        wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                 {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    end

    // ------------------------------------------------------------
    // Programmed load after reset
    // ------------------------------------------------------------
    // Constants under reset; programmed bits are taken on the first edge after release
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            load_pending_ff <= 1'b1;
        else
            load_pending_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // Latency configuration
    // ------------------------------------------------------------
    // RL1 latency register
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            latency_ff <= RST_MAX_LATENCY;
        // RL2 programmed load
        else if (load_pending_ff)
            latency_ff <= i_nv_latency_cfg;
        else if (wr_hit(ADDR_MAX_LATENCY))
            latency_ff <= (latency_ff & ~wmask[5:0]) | (i_avs_writedata[5:0] & wmask[5:0]);
    end

    // RL14 per-bank wait decode
    assign o_bank0_max_wait = lat_decode(latency_ff[LAT_W-1:0]);
    assign o_bank1_max_wait = lat_decode(latency_ff[2*LAT_W-1:LAT_W]);

    // ------------------------------------------------------------
    // Read pipeline control
    // ------------------------------------------------------------
    // RL3 pipeline register
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            pipeline_ff <= RST_PIPELINE;
        else if (load_pending_ff)
            pipeline_ff <= i_nv_pipeline_on;
        else if (wr_hit(ADDR_PIPELINE) && i_avs_byteenable[0])
            pipeline_ff <= i_avs_writedata[0];
    end

    // RL16 one inserts stage
    assign o_read_pipeline_on = pipeline_ff;

    // ------------------------------------------------------------
    // Error logic control and update enables
    // ------------------------------------------------------------
    // RL13 enable and soft reset
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ecc_control_ff <= RST_ECC_CONTROL;
        else if (load_pending_ff)
            ecc_control_ff <= i_nv_ecc_control;
        else if (wr_hit(ADDR_ECC_CONTROL) && i_avs_byteenable[0])
            ecc_control_ff <= i_avs_writedata[CTRL_W-1:0];
    end

    assign o_ecc_enable = ecc_control_ff[NUM_BANKS-1:0];
    assign o_ecc_soft_reset = ecc_control_ff[CTRL_SRST_LSB+NUM_BANKS-1:CTRL_SRST_LSB];

    // RL12 status update enable
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            update_en_ff <= RST_UPDATE_EN;
        else if (load_pending_ff)
            update_en_ff <= i_nv_update_enable;
        else if (wr_hit(ADDR_UPDATE_EN) && i_avs_byteenable[0])
            update_en_ff <= i_avs_writedata[FLAG_W-1:0];
    end

    // ------------------------------------------------------------
    // Permissions
    // ------------------------------------------------------------
    // RL7 programmed, never written
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            perm_fabric_ff <= '0;
            perm_dma_ff <= '0;
            perm_ninth_ff <= '0;
        end
        else if (load_pending_ff)
        begin
            perm_fabric_ff <= i_nv_perm_fabric;
            perm_dma_ff <= i_nv_perm_dma;
            perm_ninth_ff <= i_nv_perm_ninth;
        end
    end

    // ------------------------------------------------------------
    // Per-bank error tracking
    // ------------------------------------------------------------
    assign bank_addr[0] = i_bank0_err_addr;
    assign bank_addr[1] = i_bank1_err_addr;

    generate
        for (genvar b = 0; b < NUM_BANKS; b++)
        begin : g_bank
            // RL11 write-one clear pulse
            assign clr_pulse[b] = wr_fire && (i_avs_address == ADDR_COUNTER_CLEAR)
                && i_avs_byteenable[0] && i_avs_writedata[b];

            // RL9 event gated by update enable
            assign err_events[2*b+FLAG_1E] = i_err_1bit[b] && update_en_ff[2*b+FLAG_1E];
            assign err_events[2*b+FLAG_2E] = i_err_2bit[b] && update_en_ff[2*b+FLAG_2E];

            // RL4 counts per bank
            erc_bank_err u_bank_err
            (
                .i_sys_clk(i_sys_clk),
                .i_sys_rst(i_sys_rst),
                .i_clear(clr_pulse[b] || o_ecc_soft_reset[b]),
                .i_count_en(o_ecc_enable[b]),
                .i_err_1bit(i_err_1bit[b]),
                .i_err_2bit(i_err_2bit[b]),
                .i_err_addr(bank_addr[b]),
                .o_cnt_1e(cnt_1e[b]),
                .o_cnt_2e(cnt_2e[b]),
                .o_addr_1e(adr_1e[b]),
                .o_addr_2e(adr_2e[b])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Sticky status and interrupt
    // ------------------------------------------------------------
    // RL8 status flags
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            status_ff <= '0;
        // RL10 write one clears, new event wins
        else if (wr_hit(ADDR_ERR_STATUS) && i_avs_byteenable[0])
            status_ff <= (status_ff & ~i_avs_writedata[FLAG_W-1:0]) | err_events;
        // RL9 sticky set
        else
            status_ff <= status_ff | err_events;
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            mask_ff <= '0;
        else if (wr_hit(ADDR_IRQ_MASK) && i_avs_byteenable[0])
            mask_ff <= i_avs_writedata[FLAG_W-1:0];
    end

    // Mask bit one lets the flag through
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_irq <= 1'b0;
        else
            o_irq <= |(status_ff & mask_ff);
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // RL19 word registers, zero fill
    always_comb
    begin
        nxt_rdata = '0;
        case (i_avs_address)
            ADDR_MAX_LATENCY:
                nxt_rdata[5:0] = latency_ff;
            ADDR_ECC_CONTROL:
                nxt_rdata[CTRL_W-1:0] = ecc_control_ff;
            ADDR_UPDATE_EN:
                nxt_rdata[FLAG_W-1:0] = update_en_ff;
            ADDR_PIPELINE:
                nxt_rdata[0] = pipeline_ff;
            // RL15 double high, single low
            ADDR_RAM0_COUNTS:
                nxt_rdata = {cnt_2e[0], cnt_1e[0]};
            ADDR_RAM1_COUNTS:
                nxt_rdata = {cnt_2e[1], cnt_1e[1]};
            // RL17 two 13-bit addresses
            ADDR_RAM0_ERR_ADDR:
                nxt_rdata[2*ERR_ADDR_W-1:0] = {adr_2e[0], adr_1e[0]};
            ADDR_RAM1_ERR_ADDR:
                nxt_rdata[2*ERR_ADDR_W-1:0] = {adr_2e[1], adr_1e[1]};
            // RL6 permission readback
            ADDR_PERM_FABRIC:
                nxt_rdata[PERM_W-1:0] = perm_fabric_ff;
            ADDR_PERM_DMA:
                nxt_rdata[PERM_W-1:0] = perm_dma_ff;
            ADDR_PERM_NINTH:
                nxt_rdata[PERM_W-1:0] = perm_ninth_ff;
            ADDR_ERR_STATUS:
                nxt_rdata[FLAG_W-1:0] = status_ff;
            ADDR_IRQ_MASK:
                nxt_rdata[FLAG_W-1:0] = mask_ff;
            // Clear register is write-only, unmapped reads give zero
            default:
                nxt_rdata = '0;
        endcase
    end

    // Read data captured on the first edge, stands while waitrequest is low
    // RL18 all state reset
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            rdata_ff <= '0;
        else if (i_avs_read && !ack_ff)
            rdata_ff <= nxt_rdata;
    end

endmodule : erc_regs
